// File: core/sar_adc_defines.vh
// Constants for the 8-bit successive-approximation converter control logic
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// Register offsets on the plain register port
`define CONV_CONTROL_ADDR     3'h0
`define CONV_RESULT_ADDR      3'h1
`define PERIPH_FLAGS_ADDR     3'h2
`define PERIPH_ENABLES_ADDR   3'h3
`define IRQ_CONTROL_ADDR      3'h4

// Control register field positions
`define CLK_SEL_MSB           7
`define CLK_SEL_LSB           5
`define CHAN_SEL_MSB          4
`define CHAN_SEL_LSB          2
`define GO_BIT                1
`define ON_BIT                0

// Flag, enable and interrupt control bit positions
`define DONE_BIT              6
`define GLOBAL_EN_BIT         7
`define PERIPH_MASTER_EN_BIT  6

// Reset values
`define CONV_CONTROL_RST      8'h00
`define CONV_RESULT_RST       8'h00
`define REG_BIT_RST           1'b0
`define CLK_SEL_RST           3'h0
`define CHAN_SEL_RST          3'h0

// Clock select codes; low bits 11 select the dedicated RC clock
`define CLK_DIV2              3'b000
`define CLK_DIV4              3'b100
`define CLK_DIV8              3'b001
`define CLK_DIV16             3'b101
`define CLK_DIV32             3'b010
`define CLK_DIV64             3'b110
`define CLK_RC_LOW            2'b11

// System clocks per half bit period for each divided setting
`define HALF_DIV2             6'h01
`define HALF_DIV4             6'h02
`define HALF_DIV8             6'h04
`define HALF_DIV16            6'h08
`define HALF_DIV32            6'h10
`define HALF_DIV64            6'h20

// Channel select codes
`define CHAN_PIN0             3'b000
`define CHAN_PIN1             3'b001
`define CHAN_PIN2             3'b010
`define CHAN_TEMP             3'b110
`define CHAN_FIXED_REF        3'b111

// One conversion lasts 9.5 bit periods, counted as 19 half periods
`define HALF_PERIODS_PER_CONV 5'h13
`define LAST_HALF_INDEX       5'h12
`define BIT_HALF_PERIODS      5'h10

`endif

// File: core/conv_clock_divider.v
// Half bit period enable generator from system clock or dedicated RC clock
`timescale 1ns/100ps
`include "sar_adc_defines.vh"

module conv_clock_divider
(
   input  wire       ref_clk_i,   // System clock
   input  wire       rst_i,       // Synchronous reset, active high
   input  wire       run_i,       // Count while high, restart when low
   input  wire [2:0] clk_sel_i,   // Conversion clock select
   input  wire       rc_tick_i,   // One pulse per RC clock half period
   output reg        half_tick_o  // One-cycle pulse per half bit period
);

   reg  [5:0] half_len;
   reg  [5:0] cnt_q;
   wire       rc_sel;

   assign rc_sel = (clk_sel_i[1:0] == `CLK_RC_LOW);

   // Half period length, in system clocks, for each divided setting
   always @*
   begin
      case (clk_sel_i)
         `CLK_DIV2  : half_len = `HALF_DIV2;
         `CLK_DIV4  : half_len = `HALF_DIV4;
         `CLK_DIV8  : half_len = `HALF_DIV8;
         `CLK_DIV16 : half_len = `HALF_DIV16;
         `CLK_DIV32 : half_len = `HALF_DIV32;
         `CLK_DIV64 : half_len = `HALF_DIV64;
         default    : half_len = `HALF_DIV2;
      endcase
   end

   // Divided settings count system clocks, so the rate follows the system clock
   always @(posedge ref_clk_i)
   begin
      if (rst_i || !run_i)
      begin
         cnt_q       <= 6'h00;
         half_tick_o <= 1'b0;
      end
      else if (rc_sel)
      begin
         cnt_q       <= 6'h00;
         half_tick_o <= rc_tick_i;
      end
      else if (cnt_q == half_len - 6'h01)
      begin
         cnt_q       <= 6'h00;
         half_tick_o <= 1'b1;
      end
      else
      begin
         cnt_q       <= cnt_q + 6'h01;
         half_tick_o <= 1'b0;
      end
   end

endmodule // conv_clock_divider

// File: core/sar_bit_engine.v
// Successive-approximation trial register with partial result fill
`timescale 1ns/100ps

module sar_bit_engine #(
   parameter WIDTH = 8
)
(
   input  wire             ref_clk_i,  // System clock
   input  wire             rst_i,      // Synchronous reset, active high
   input  wire             start_i,    // Clear trial state for a new conversion
   input  wire             trial_i,    // Set the trial bit at idx_i
   input  wire             resolve_i,  // Keep or drop the bit at idx_i
   input  wire [2:0]       idx_i,      // Bit under test
   input  wire             comp_i,     // Comparator: input at or above DAC
   output reg  [WIDTH-1:0] code_o,     // DAC trial code
   output wire [WIDTH-1:0] partial_o   // Result with unresolved bits filled
);

   reg [WIDTH-1:0] done_mask_q;
   reg             last_bit_q;

   // Trial and resolve steps; bits are tested from the top down
   always @(posedge ref_clk_i)
   begin
      if (rst_i || start_i)
      begin
         code_o      <= {WIDTH{1'b0}};
         done_mask_q <= {WIDTH{1'b0}};
         last_bit_q  <= 1'b0;
      end
      else if (trial_i)
      begin
         code_o[idx_i] <= 1'b1;
      end
      else if (resolve_i)
      begin
         code_o[idx_i]      <= comp_i;
         done_mask_q[idx_i] <= 1'b1;
         last_bit_q         <= comp_i;
      end
   end

   // Unresolved bits copy the last bit resolved
   genvar b;
   generate
      for (b = 0; b < WIDTH; b = b + 1)
      begin : g_fill
         assign partial_o[b] = done_mask_q[b] ? code_o[b] : last_bit_q;
      end
   endgenerate

endmodule // sar_bit_engine

// File: core/sar_adc_sequencer_8bit.v
// Control logic of the 8-bit successive-approximation converter
// Function
// - Route exactly the selected input to the single sample-and-hold stage.
// - Conversion reference is the supply only; fixed reference is input only.
// - Clock select codes map to divide ratios; codes ending 11 pick RC clock.
// - A conversion takes 9.5 bit periods, one result bit per period.
// - Divided conversion clocks follow the system clock directly.
// - Done flag sets at every completed conversion, regardless of enable.
// - Done flag is cleared only by software, never by hardware.
// - Interrupt request is done flag and enable; in sleep it wakes.
// - Wake resumes next instruction; vector only with global and peripheral enables.
// - Writing go while converter is on starts a conversion.
// - Completion clears go, sets done flag and loads the result.
// - Clearing go early stops and stores partial result, lower bits filled.
// - Reset restores all registers, switches converter off, ends conversion.
// - RC clock delays start one instruction cycle; only RC converts in sleep.
// - Sleep RC conversion wakes if enabled, else powers down, on bit kept.
// - Sleep with divided clock aborts and powers down, on bit kept.
// - Channel codes 000-010 pins, 110 temperature, 111 fixed reference.
// - An early stop by software does not set the done flag.
// - Control holds clock select 7:5, channel 4:2, go 1, on 0.
`timescale 1ns/100ps
`include "sar_adc_defines.vh"

module sar_adc_sequencer_8bit #(
   parameter RES_WIDTH = 8
)
(
   input  wire                 ref_clk_i,     // 40 MHz system clock
   input  wire                 rst_i,         // Synchronous reset, active high
   input  wire [2:0]           addr_i,        // Register address
   input  wire [7:0]           wr_data_i,     // Register write data
   input  wire                 wr_i,          // Write strobe
   input  wire                 rd_i,          // Read strobe
   output reg  [7:0]           rd_data_o,     // Read data, cycle after strobe
   input  wire                 comp_i,        // Comparator: input at or above DAC
   input  wire                 rc_tick_i,     // RC clock half period pulse
   input  wire                 instr_tick_i,  // Instruction cycle pulse
   input  wire                 sleep_exec_i,  // Sleep instruction executed pulse
   input  wire                 in_sleep_i,    // Device is asleep
   output reg  [4:0]           chan_onehot_o, // Pin0, pin1, pin2, temp, fixed ref
   output reg                  conv_power_o,  // Analog converter powered
   output reg                  sample_o,      // Sample switch closed
   output reg  [RES_WIDTH-1:0] dac_code_o,    // DAC trial code, spans supply
   output reg                  irq_o,         // Converter interrupt request
   output reg                  wake_o,        // Wake request while asleep
   output reg                  vector_o       // Take the service routine
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_CONV = 3'b100;

   reg  [2:0]           clk_sel_q;
   reg  [2:0]           chan_sel_q;
   reg                  go_q;
   reg                  on_q;
   reg  [RES_WIDTH-1:0] result_q;
   reg                  done_flag_q;
   reg                  done_en_q;
   reg                  global_en_q;
   reg                  periph_master_en_q;
   reg                  sleep_off_q;
   reg  [2:0]           state_q;
   reg  [2:0]           state_d;
   reg  [4:0]           half_cnt_q;
   reg  [7:0]           rd_mux;
   reg  [4:0]           chan_dec;

   wire                 rc_sel;
   wire                 ctl_wr;
   wire                 flag_wr;
   wire                 half_tick;
   wire                 start_now;
   wire                 finish;
   wire                 sw_abort;
   wire                 sleep_abort;
   wire                 go_request;
   wire                 trial;
   wire                 resolve;
   wire [2:0]           bit_idx;
   wire [RES_WIDTH-1:0] code;
   wire [RES_WIDTH-1:0] partial;
   wire                 irq_level;

   assign rc_sel  = (clk_sel_q[1:0] == `CLK_RC_LOW);
   assign ctl_wr  = wr_i && (addr_i == `CONV_CONTROL_ADDR);
   assign flag_wr = wr_i && (addr_i == `PERIPH_FLAGS_ADDR);

   // Go is only taken when the on bit was already set before this write
   assign go_request = ctl_wr && wr_data_i[`GO_BIT] && on_q && !go_q;

   // Software stop: go written low, or on bit dropped, mid conversion
   assign sw_abort = ctl_wr && (state_q != ST_IDLE)
                     && (!wr_data_i[`GO_BIT] || !wr_data_i[`ON_BIT]);

   // Sleep kills a conversion running on a divided system clock
   assign sleep_abort = sleep_exec_i && !rc_sel && (state_q != ST_IDLE);

   // RC clock waits for one more instruction cycle before converting
   assign start_now = (state_q == ST_WAIT) && instr_tick_i;

   // Half period index: even counts set a trial, odd counts resolve it
   assign trial   = (state_q == ST_CONV) && half_tick && (half_cnt_q < `BIT_HALF_PERIODS)
                    && !half_cnt_q[0];
   assign resolve = (state_q == ST_CONV) && half_tick && (half_cnt_q < `BIT_HALF_PERIODS)
                    && half_cnt_q[0];
   assign bit_idx = 3'd7 - half_cnt_q[3:1];
   assign finish  = (state_q == ST_CONV) && half_tick
                    && (half_cnt_q == `LAST_HALF_INDEX);

   assign irq_level = done_flag_q && done_en_q;

   // Conversion clock enables; held in restart outside a conversion
   conv_clock_divider u_divider
   (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .run_i       (state_q == ST_CONV),
      .clk_sel_i   (clk_sel_q),
      .rc_tick_i   (rc_tick_i),
      .half_tick_o (half_tick)
   );

   // Trial register; cleared whenever a conversion is launched
   sar_bit_engine #(
      .WIDTH (RES_WIDTH)
   ) u_engine
   (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .start_i   (go_request || start_now),
      .trial_i   (trial),
      .resolve_i (resolve),
      .idx_i     (bit_idx),
      .comp_i    (comp_i),
      .code_o    (code),
      .partial_o (partial)
   );

   // Sequencer next state
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE :
            if (go_request)
               state_d = rc_sel ? ST_WAIT : ST_CONV;
         ST_WAIT :
            if (sw_abort || sleep_abort)
               state_d = ST_IDLE;
            else if (start_now)
               state_d = ST_CONV;
         ST_CONV :
            if (sw_abort || sleep_abort || finish)
               state_d = ST_IDLE;
         default :
            state_d = ST_IDLE;
      endcase
   end

   // State and half period counter; reset ends any conversion at once
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_q    <= ST_IDLE;
         half_cnt_q <= 5'h00;
      end
      else
      begin
         state_q <= state_d;
         if (state_d != ST_CONV || state_q != ST_CONV)
            half_cnt_q <= 5'h00;
         else if (half_tick)
            half_cnt_q <= half_cnt_q + 5'h01;
      end
   end

   // Control register fields and the go flag
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         clk_sel_q  <= `CLK_SEL_RST;
         chan_sel_q <= `CHAN_SEL_RST;
         go_q       <= `REG_BIT_RST;
         on_q       <= `REG_BIT_RST;
      end
      else
      begin
         if (ctl_wr)
         begin
            clk_sel_q  <= wr_data_i[`CLK_SEL_MSB:`CLK_SEL_LSB];
            chan_sel_q <= wr_data_i[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
            on_q       <= wr_data_i[`ON_BIT];
         end
         // Hardware drop of go beats nothing: the write already asked for it
         if (go_request)
            go_q <= 1'b1;
         else if (finish || sleep_abort || sw_abort)
            go_q <= 1'b0;
         else if (ctl_wr && !wr_data_i[`ON_BIT])
            go_q <= 1'b0;
      end
   end

   // Result register: full result at completion, filled partial on a software stop in ST_CONV
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
         result_q <= `CONV_RESULT_RST;
      else if (finish)
         result_q <= code;
      else if (sw_abort && state_q == ST_CONV)
         result_q <= partial;
      else if (wr_i && addr_i == `CONV_RESULT_ADDR)
         result_q <= wr_data_i[RES_WIDTH-1:0];
   end

   // Done flag: hardware set wins over a software clear in the same cycle
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
         done_flag_q <= `REG_BIT_RST;
      else if (finish)
         done_flag_q <= 1'b1;
      else if (flag_wr)
         done_flag_q <= wr_data_i[`DONE_BIT];
   end

   // Interrupt enables
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         done_en_q          <= `REG_BIT_RST;
         global_en_q        <= `REG_BIT_RST;
         periph_master_en_q <= `REG_BIT_RST;
      end
      else
      begin
         if (wr_i && addr_i == `PERIPH_ENABLES_ADDR)
            done_en_q <= wr_data_i[`DONE_BIT];
         if (wr_i && addr_i == `IRQ_CONTROL_ADDR)
         begin
            global_en_q        <= wr_data_i[`GLOBAL_EN_BIT];
            periph_master_en_q <= wr_data_i[`PERIPH_MASTER_EN_BIT];
         end
      end
   end

   // Sleep power-down; the on bit itself stays set, power returns on waking
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
         sleep_off_q <= 1'b0;
      else if (sleep_abort)
         sleep_off_q <= 1'b1;
      else if (finish && in_sleep_i && !done_en_q)
         sleep_off_q <= 1'b1;
      else if (!in_sleep_i)
         sleep_off_q <= 1'b0;
   end

   // Channel decode; reserved codes leave every switch open
   always @*
   begin
      case (chan_sel_q)
         `CHAN_PIN0      : chan_dec = 5'h01;
         `CHAN_PIN1      : chan_dec = 5'h02;
         `CHAN_PIN2      : chan_dec = 5'h04;
         `CHAN_TEMP      : chan_dec = 5'h08;
         `CHAN_FIXED_REF : chan_dec = 5'h10;
         default         : chan_dec = 5'h00;
      endcase
   end

   // Analog-side outputs, all registered
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         chan_onehot_o <= 5'h00;
         conv_power_o  <= 1'b0;
         sample_o      <= 1'b0;
         dac_code_o    <= {RES_WIDTH{1'b0}};
      end
      else
      begin
         chan_onehot_o <= chan_dec;
         conv_power_o  <= on_q && !sleep_off_q;
         // Hold opens on the first half period of a conversion
         sample_o      <= on_q && !sleep_off_q && chan_dec != 5'h00
                          && (state_q != ST_CONV);
         // The DAC ladder spans ground to supply; the fixed reference is never the top.
         // It mirrors the trial register, so a trial is on the ladder by the next tick.
         if (go_request || start_now)
            dac_code_o <= {RES_WIDTH{1'b0}};
         else if (trial)
            dac_code_o[bit_idx] <= 1'b1;
         else if (resolve)
            dac_code_o[bit_idx] <= comp_i;
      end
   end

   // Interrupt, wake and vector requests
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         irq_o    <= 1'b0;
         wake_o   <= 1'b0;
         vector_o <= 1'b0;
      end
      else
      begin
         irq_o    <= irq_level;
         wake_o   <= irq_level && in_sleep_i;
         vector_o <= irq_level && global_en_q && periph_master_en_q;
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always @*
   begin
      rd_mux = 8'h00;
      case (addr_i)
         `CONV_CONTROL_ADDR   : rd_mux = {clk_sel_q, chan_sel_q, go_q, on_q};
         `CONV_RESULT_ADDR    : rd_mux = result_q;
         `PERIPH_FLAGS_ADDR   : rd_mux[`DONE_BIT] = done_flag_q;
         `PERIPH_ENABLES_ADDR : rd_mux[`DONE_BIT] = done_en_q;
         `IRQ_CONTROL_ADDR    :
         begin
            rd_mux[`GLOBAL_EN_BIT]        = global_en_q;
            rd_mux[`PERIPH_MASTER_EN_BIT] = periph_master_en_q;
         end
         default              : rd_mux = 8'h00;
      endcase
   end

   // Read data stand for one cycle after the strobe, zero otherwise
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
         rd_data_o <= 8'h00;
      else
         rd_data_o <= rd_i ? rd_mux : 8'h00;
   end

endmodule // sar_adc_sequencer_8bit

// File: test/analog_front_model.sv
// Behavioural analog side: source level, comparator and RC clock ticks
`timescale 1ns/100ps
module analog_front_model
(
   input  wire logic       ref_clk_i, // System clock
   input  wire logic [4:0] chan_i,    // One-hot channel switches
   input  wire logic [7:0] dac_i,     // DAC trial code
   input  wire logic [7:0] level_i,   // Level on every source
   output wire logic       comp_o,    // Comparator decision
   output wire logic       rc_tick_o  // RC half period pulse
);
   logic [2:0] rc_cnt_q = 3'h0;
   logic       tick_q   = 1'b0;
   logic       float_q  = 1'b0;
   // RC oscillator gives a half period every six clocks, unrelated to go
   always @(posedge ref_clk_i)
   begin
      float_q  <= ~float_q;
      rc_cnt_q <= (rc_cnt_q == 3'h5) ? 3'h0 : rc_cnt_q + 3'h1;
      tick_q   <= (rc_cnt_q == 3'h5);
   end
   // A floating input never settles, so an open switch toggles the comparator
   assign comp_o    = (chan_i != 5'h00) ? (level_i >= dac_i) : float_q;
   assign rc_tick_o = tick_q;
endmodule // analog_front_model

// File: test/sar_adc_sequencer_8bit_properties.sv
// Port assertions for the converter sequencer
`timescale 1ns/100ps
module sar_adc_checker
(
   input wire logic       ref_clk_i,     // Clock
   input wire logic       rst_i,         // Reset
   input wire logic [2:0] addr_i,        // Address
   input wire logic       wr_i,          // Write strobe
   input wire logic       rd_i,          // Read strobe
   input wire logic [7:0] rd_data_o,     // Read data
   input wire logic       in_sleep_i,    // Asleep
   input wire logic [4:0] chan_onehot_o, // Channel switches
   input wire logic       conv_power_o,  // Power
   input wire logic       irq_o,         // Interrupt
   input wire logic       wake_o,        // Wake
   input wire logic       vector_o       // Vector
);
   // Only a software write to flags or enables may lower the interrupt
   wire flag_wr = wr_i && (addr_i == 3'h2 || addr_i == 3'h3);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_rd_idle;
      !$past(rd_i) |-> rd_data_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unmapped;
      rd_i && addr_i > 3'h4 |=> rd_data_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_flag_bits;
      rd_i && (addr_i == 3'h2 || addr_i == 3'h3) |=> (rd_data_o & 8'hBF) == 8'h00;
   endproperty
   a_flag_bits: assert property (p_flag_bits) else $error("spare flag bits");
   property p_chan;
      $onehot0(chan_onehot_o);
   endproperty
   a_chan: assert property (p_chan) else $error("two channels on");
   property p_reset;
      $fell(rst_i) |-> !conv_power_o && !irq_o && !wake_o && !vector_o && !chan_onehot_o;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left state");
   property p_wake;
      wake_o |-> $past(in_sleep_i) || $past(in_sleep_i, 2);
   endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   property p_vector;
      vector_o |-> irq_o || $past(irq_o) || $past(irq_o, 2);
   endproperty
   a_vector: assert property (p_vector) else $error("vector without irq");
   property p_irq_hold;
      $fell(irq_o) |-> $past(flag_wr) || $past(flag_wr, 2) || $past(flag_wr, 3);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
endmodule // sar_adc_checker

bind sar_adc_sequencer_8bit sar_adc_checker u_checker
(
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .in_sleep_i(in_sleep_i), .chan_onehot_o(chan_onehot_o),
   .conv_power_o(conv_power_o), .irq_o(irq_o), .wake_o(wake_o), .vector_o(vector_o)
);

// File: test/sar_adc_sequencer_8bit_tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_8bit_tb_top;
   logic       ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic       instr_tick_i = 1'b0, sleep_exec_i = 1'b0, in_sleep_i = 1'b0;
   logic [2:0] addr_i    = 3'h0;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] level     = 8'h00;
   logic [1:0] icnt_q    = 2'h0;
   logic [7:0] rd_data_o, dac_code_o;
   logic [4:0] chan_onehot_o;
   logic       comp_i, rc_tick_i, conv_power_o, sample_o, irq_o, wake_o, vector_o;
   int         err_total = 0;
   int         check_count = 0;
   sar_adc_sequencer_8bit dut
   (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .comp_i(comp_i),
      .rc_tick_i(rc_tick_i), .instr_tick_i(instr_tick_i), .sleep_exec_i(sleep_exec_i),
      .in_sleep_i(in_sleep_i), .chan_onehot_o(chan_onehot_o), .conv_power_o(conv_power_o),
      .sample_o(sample_o), .dac_code_o(dac_code_o), .irq_o(irq_o), .wake_o(wake_o),
      .vector_o(vector_o)
   );
   analog_front_model far_side
   (
      .ref_clk_i(ref_clk_i), .chan_i(chan_onehot_o), .dac_i(dac_code_o),
      .level_i(level), .comp_o(comp_i), .rc_tick_o(rc_tick_i)
   );
   // 40 MHz clock; an instruction cycle is four clocks
   initial
   begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      icnt_q       <= icnt_q + 2'h1;
      instr_tick_i <= (icnt_q == 2'h3);
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycles end with a quiet cycle so a strobe is never reassigned at one edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk(rd_data_o, exp);
      @(posedge ref_clk_i);
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1 n++;
      end while (irq_o !== 1'b1 && n < 3000);
      @(posedge ref_clk_i);
   endtask
   task automatic t_regs;
      logic [4:0] onehot [8] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00, 5'h08, 5'h10};
      for (int a = 0; a < 8; a++)
         rdc(3'(a), 8'h00);
      wr(3'h7, 8'hFF);
      rdc(3'h7, 8'h00);
      wr(3'h0, 8'h03);
      rdc(3'h0, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         wr(3'h0, {3'h0, 3'(c), 2'h1});
         rdc(3'h0, {3'h0, 3'(c), 2'h1});
         chk(8'(chan_onehot_o), 8'(onehot[c]));
         chk(8'(sample_o), 8'(onehot[c] != 5'h00));
      end
   endtask
   // All six divided clock codes and RC code 011, conversion length measured up to the interrupt
   task automatic t_convert;
      // Settings below the minimum bit period still run: the model needs no settling
      logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
      int         halfs [7] = '{1, 2, 4, 8, 16, 32, 6};
      int         n;
      bit         ok;
      wr(3'h3, 8'h40);
      for (int k = 0; k < 7; k++)
      begin
         level <= 8'h5A + 8'(k * 37);
         wr(3'h2, 8'h00);
         wr(3'h0, {codes[k], 5'h01});
         repeat (8) @(posedge ref_clk_i);
         wr(3'h0, {codes[k], 5'h03});
         wait_irq(n);
         // Divided clocks start on a fixed phase; free RC ticks land anywhere in a period
         ok = (k < 6) ? (n == 19 * halfs[k] + 1) : (n >= 111 && n <= 119);
         chk(8'(ok), 8'h01);
         rdc(3'h1, 8'h5A + 8'(k * 37));
         chk(dac_code_o, 8'h5A + 8'(k * 37));
         rdc(3'h0, {codes[k], 5'h01});
         rdc(3'h2, 8'h40);
      end
   endtask
   // Stop after three bits of a slow conversion
   task automatic t_abort;
      wr(3'h2, 8'h00);
      level <= 8'hB0;
      wr(3'h0, 8'hC1);
      repeat (8) @(posedge ref_clk_i);
      wr(3'h0, 8'hC3);
      repeat (228) @(posedge ref_clk_i);
      chk(8'(sample_o), 8'h00);
      wr(3'h0, 8'hC1);
      rdc(3'h1, 8'hBF);
      rdc(3'h2, 8'h00);
   endtask
   task automatic t_sleep_div;
      wr(3'h0, 8'hC3);
      repeat (50) @(posedge ref_clk_i);
      sleep_exec_i <= 1'b1;
      in_sleep_i   <= 1'b1;
      @(posedge ref_clk_i);
      sleep_exec_i <= 1'b0;
      rdc(3'h0, 8'hC1);
      rdc(3'h2, 8'h00);
      chk(8'(conv_power_o), 8'h00);
      in_sleep_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask
   // RC conversion across a sleep, with the interrupt enabled or not
   task automatic t_sleep_rc(input logic ie);
      wr(3'h3, {1'b0, ie, 6'h00});
      wr(3'h4, 8'h00);
      wr(3'h2, 8'h00);
      level <= 8'h3C;
      wr(3'h0, 8'h61);
      repeat (8) @(posedge ref_clk_i);
      wr(3'h0, 8'h63);
      sleep_exec_i <= 1'b1;
      in_sleep_i   <= 1'b1;
      @(posedge ref_clk_i);
      sleep_exec_i <= 1'b0;
      repeat (200) @(posedge ref_clk_i);
      chk(8'(wake_o), 8'(ie));
      chk(8'(conv_power_o), 8'(ie));
      chk(8'(vector_o), 8'h00);
      wr(3'h4, 8'hC0);
      repeat (4) @(posedge ref_clk_i);
      chk(8'(vector_o), 8'(ie));
      in_sleep_i <= 1'b0;
      rdc(3'h2, 8'h40);
      rdc(3'h0, 8'h61);
      wr(3'h2, 8'h00);
      repeat (3) @(posedge ref_clk_i);
      chk(8'(irq_o), 8'h00);
   endtask
   task automatic t_reset_mid;
      wr(3'h0, 8'hC3);
      repeat (40) @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      chk(8'(conv_power_o), 8'h00);
      for (int a = 0; a < 5; a++)
         rdc(3'(a), 8'h00);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_regs();
      t_convert();
      t_abort();
      t_sleep_div();
      t_sleep_rc(1'b0);
      t_sleep_rc(1'b1);
      t_reset_mid();
      tally_and_finish();
   end
   // The whole run needs under 6000 clocks
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      tally_and_finish();
   end
endmodule // sar_adc_sequencer_8bit_tb_top
